// ===== bench/vout_target_registers_test.sv
module vout_target_registers_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, rstn_i, ce_i, cmd_wr_i, cmd_rd_i, cmd_rvalid_o, converting_i;
    logic rail_disabled_i, address_or_reset_pin_i, output_reset_pin_enable_i, nvm_restore_i;
    logic margin_up_default_bit_i, margin_down_default_bit_i, margin_up_store_bit_o;
    logic limit_warn_o, status_word_vout_o, status_byte_other_o, invalid_data_o, alert_o;
    logic [7:0] cmd_code_i, operation_i, transition_rate_i;
    logic [15:0] cmd_wdata_i, cmd_rdata_o, boot_voltage_offset_i, floor_i, commanded_o, dac_code_o;
    logic [3:0] loop_scale_mant_i;
    logic [2:0] margin_up_band_o;
    logic [31:0] seed = 32'he6630680, r;
    int err_count, n_compared, n_warn, n_inv, t, o, c, mu, md, b, k;
    vtr_core DUT (.*);
    vtr_host host (.sys_clk_i(sys_clk_i), .rdata_i(cmd_rdata_o), .rvalid_i(cmd_rvalid_o),
        .wr_o(cmd_wr_i), .rd_o(cmd_rd_i), .code_o(cmd_code_i), .wdata_o(cmd_wdata_i));
    ////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // reference: margins, then ceiling, dac and zero clamps
    function automatic logic [15:0] model(input logic [7:0] op);
        int v;
        v = t + o;
        if (op[5]) v += (t * (mu - 512)) >>> 9;
        if (op[4]) v -= (t * (512 - md)) >>> 9;
        if (v > c) v = c;
        if (v > int'(vtr_pkg::DAC_MAX_CODE)) v = int'(vtr_pkg::DAC_MAX_CODE);
        if (v < 0) v = 0;
        return 16'(v);
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] code, input logic [15:0] exp, input string nm);
        logic [15:0] d;
        logic ok;
        host.rd(code, d, ok);
        chk("rvalid", {15'h0, ok}, 16'h0001);
        chk(nm, d, exp);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // pulses are counted, so their exact cycle is free
    always @(posedge sys_clk_i) begin
        if (limit_warn_o === 1'b1) n_warn++;
        if (invalid_data_o === 1'b1) n_inv++;
    end
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // give up well past the expected length
    initial begin
        #600000;
        err_count++;
        conclude();
    end
    initial begin
        r = rnd();
        {rstn_i, ce_i, converting_i, rail_disabled_i, nvm_restore_i} = 5'b01000;
        {address_or_reset_pin_i, output_reset_pin_enable_i} = 2'b10;
        {margin_up_default_bit_i, margin_down_default_bit_i} = 2'b11;
        {operation_i, transition_rate_i, floor_i} = {8'h00, 8'hff, 16'h0000};
        boot_voltage_offset_i = {6'h01, r[9:0]};
        loop_scale_mant_i = 4'(1 << r[13:12]);
        b = int'(boot_voltage_offset_i >> r[13:12]);
        repeat (2) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        {t, o, c, mu, md} = {b, 32'h0, 32'hb80, 32'h210, 32'h1f0};
        rdchk(8'h21, 16'(b), "boot target");
        rdchk(8'h24, 16'h0b80, "ceiling");
        rdchk(8'h23, 16'h0000, "unmapped");
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            {o, c, mu, md} = {int'($signed(r[6:0])), 2048 + int'(r[16:8]), 512 + int'(r[22:17]),
                480 + int'(r[27:23])};
            host.wr(8'h22, {{9{r[6]}}, r[6:0]});
            host.wr(8'h24, 16'(c));
            host.wr(8'h25, 16'(mu));
            host.wr(8'h26, 16'(md));
            t = 64 + int'(r[31:28]) * 60;
            operation_i = {2'b00, 2'(i), 4'h0};
            host.wr(8'h21, {3'(rnd()), 13'(t)});
            rdchk(8'h21, 16'(t), "target");
            rdchk(8'h22, 16'(o), "offset");
            rdchk(8'h24, 16'(c), "ceiling");
            rdchk(8'h25, 16'(mu), "margin up");
            chk("commanded", commanded_o, model(operation_i));
        end
        $display("field test done");
        {k, operation_i} = {n_inv, 8'h00};
        host.wr(8'h22, 16'h0100);
        host.wr(8'h24, 16'h1800);
        host.wr(8'h25, 16'h0800);
        host.wr(8'h26, 16'h0400);
        repeat (3) @(negedge sys_clk_i);
        chk("invalid count", 16'(n_inv - k), 16'h0004);
        rdchk(8'h22, 16'(o), "offset kept");
        k = n_warn;
        host.wr(8'h21, 16'h1fff);
        rdchk(8'h21, 16'(c), "ceiling clamp");
        chk("warn", 16'(n_warn > k), 16'h0001);
        {k, c} = {n_warn, c - 100};
        host.wr(8'h24, 16'(c));
        rdchk(8'h21, 16'(c), "ceiling lowered");
        chk("warn", 16'(n_warn > k), 16'h0001);
        floor_i = 16'd1500;
        host.wr(8'h21, 16'd1000);
        rdchk(8'h21, 16'd1500, "floor clamp");
        floor_i = 16'h0000;
        $display("limit test done");
        rail_disabled_i = 1'b1;
        @(negedge sys_clk_i);
        rail_disabled_i = 1'b0;
        rdchk(8'h21, 16'(b), "rail off");
        host.wr(8'h21, 16'd900);
        {output_reset_pin_enable_i, address_or_reset_pin_i} = 2'b10;
        repeat (6) @(negedge sys_clk_i);
        address_or_reset_pin_i = 1'b1;
        rdchk(8'h21, 16'(b), "reset pin");
        nvm_restore_i = 1'b1;
        @(negedge sys_clk_i);
        nvm_restore_i = 1'b0;
        rdchk(8'h25, 16'd536, "restore up");
        rdchk(8'h26, 16'd488, "restore down");
        chk("band", 16'({margin_up_store_bit_o, margin_up_band_o}), 16'ha);
        $display("reload test done");
        {converting_i, o, t} = {1'b1, 32'h30, 32'h3e8};
        host.wr(8'h22, 16'd48);
        repeat (50) @(negedge sys_clk_i);
        host.wr(8'h21, 16'd1000);
        repeat (3) @(negedge sys_clk_i);
        for (k = 0; k < 20000 && dac_code_o !== commanded_o; k++) @(negedge sys_clk_i);
        chk("dac slewed", dac_code_o, model(8'h00));
        $display("slew test done");
        conclude();
    end
endmodule

// ===== bench/vtr_assertions.sv
module vtr_checker (
    input wire logic sys_clk_i, // clock
    input wire logic rstn_i, // reset
    input wire logic ce_i, // enable
    input wire logic cmd_wr_i, // write
    input wire logic cmd_rd_i, // read
    input wire logic [7:0] cmd_code_i, // code
    input wire logic [15:0] cmd_wdata_i, // wdata
    input wire logic [15:0] cmd_rdata_o, // rdata
    input wire logic [15:0] commanded_o, // commanded
    input wire logic limit_warn_o, // warn
    input wire logic status_word_vout_o, // word
    input wire logic status_byte_other_o, // byte
    input wire logic invalid_data_o, // invalid
    input wire logic alert_o // alert
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic rd_ok;
    ////////////////////////////////////////////////////////
    // reads count only when enabled
    assign rd_ok = ce_i && cmd_rd_i;
    AST_TGT_TOP: assert property (rd_ok && cmd_code_i == 8'h21 |=> cmd_rdata_o[15:13] == 3'h0)
        else $error("target top bits set");
    AST_OFS_SIGN: assert property (rd_ok && cmd_code_i == 8'h22 |=> cmd_rdata_o[15:7]
        == {9{cmd_rdata_o[6]}}) else $error("offset not sign extended");
    AST_CEIL_TOP: assert property (rd_ok && cmd_code_i == 8'h24 |=> cmd_rdata_o[15:12] == 4'h0)
        else $error("ceiling top bits set");
    AST_MUP_TOP: assert property (rd_ok && cmd_code_i == 8'h25 |=> cmd_rdata_o[15:11] == 5'h00)
        else $error("margin up top bits set");
    AST_CEIL_BAD: assert property (ce_i && cmd_wr_i && cmd_code_i == 8'h24
        && cmd_wdata_i[15:12] != 4'h0 |-> ##[1:2] invalid_data_o) else $error("no invalid flag");
    AST_ALERT: assert property (alert_o == (limit_warn_o || invalid_data_o))
        else $error("alert not tied to events");
    AST_STATUS: assert property (limit_warn_o |-> status_word_vout_o && status_byte_other_o)
        else $error("status bits missing");
    AST_DAC_MAX: assert property (commanded_o <= vtr_pkg::DAC_MAX_CODE)
        else $error("commanded above dac range");
endmodule
bind vtr_core vtr_checker u_chk (.*);

// ===== bench/vtr_host.sv
module vtr_host (
    input wire logic sys_clk_i, // clock
    input wire logic [15:0] rdata_i, // read word
    input wire logic rvalid_i, // read valid
    output logic wr_o, // write strobe
    output logic rd_o, // read strobe
    output logic [7:0] code_o, // command code
    output logic [15:0] wdata_o // write word
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        code_o = 8'h00;
        wdata_o = 16'h0000;
    end
    // released data is inverted, not left stale
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge sys_clk_i);
        code_o = c;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge sys_clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    // answer stands one cycle after the strobe
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
        @(negedge sys_clk_i);
        code_o = c;
        rd_o = 1'b1;
        @(negedge sys_clk_i);
        rd_o = 1'b0;
        ok = rvalid_i;
        d = rdata_i;
    endtask
endmodule

// ===== common/vtr_pkg.sv
package vtr_pkg;
    // command codes of the output voltage command group
    localparam logic [7:0] OFS_TARGET = 8'h21;
    localparam logic [7:0] OFS_OFFSET = 8'h22;
    localparam logic [7:0] OFS_CEILING = 8'h24;
    localparam logic [7:0] OFS_MARGIN_UP = 8'h25;
    localparam logic [7:0] OFS_MARGIN_DOWN = 8'h26;

    // field layouts: width of the writable part of each command
    localparam int TARGET_W = 13;
    localparam int OFFSET_W = 7;
    localparam int CEILING_W = 12;
    localparam int MUP_W = 11;
    localparam int MDN_W = 10;
    localparam int OFFSET_SIGN_BIT = 6;

    // operation margin bit positions
    localparam int OP_MARGIN_HIGH_BIT = 5;
    localparam int OP_MARGIN_LOW_BIT = 4;

    // reset and restore values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [10:0] MUP_DEFAULT_0 = 11'h210;
    localparam logic [10:0] MUP_DEFAULT_1 = 11'h218;
    localparam logic [9:0] MDN_DEFAULT_0 = 10'h1f0;
    localparam logic [9:0] MDN_DEFAULT_1 = 10'h1e8;
    localparam logic [11:0] CEILING_DEFAULT = 12'hb80;

    // relative factor of one with exponent -9, and its shift
    localparam logic [11:0] FACTOR_UNITY = 12'h200;
    localparam int FACTOR_SHIFT = 9;

    // margin-up classification bands for nonvolatile storage
    localparam logic [10:0] MUP_BAND_LOW = 11'h20c;
    localparam logic [10:0] MUP_BAND_TOP = 11'h23c;
    localparam int MUP_BAND_STEP_LOG2 = 3;
    localparam logic [2:0] MUP_BAND_BIT1_MIN = 3'h2;

    // largest code the dac accepts
    localparam logic [15:0] DAC_MAX_CODE = 16'h0b80;

    // slew timing: transition rate counted per microsecond
    localparam int CLK_MHZ = 100;
    localparam int SLEW_TICK_NS = 1000;
    localparam int SLEW_TICK_CYC = (SLEW_TICK_NS * CLK_MHZ) / 1000;
    // rate lsb is 0.125 mV = 8/64 mV, code lsb is 1.953125 mV = 125/64 mV
    localparam logic [11:0] RATE_UNIT = 12'h008;
    localparam logic [11:0] CODE_UNIT = 12'h07d;
    localparam logic [7:0] RATE_FLOOR = 8'h05;
endpackage

// ===== hdl/vtr_core.sv
// Operation
// - target bits 15:13 ignore writes and read zero; 12:0 hold data
// - commanded = target + offset + margin-up and margin-down terms, exponent scaled
// - at power-up target loads boot offset divided by loop scale mantissa
// - rail disabled by on/off or fault reloads target with boot voltage
// - address/reset pin asserted, when enabled, returns target to boot voltage
// - target write beyond ceiling or floor is replaced by violated limit
// - a limit clamp raises the limit warning and alerts the host
// - offset adds signed amount; resulting changes slew at transition rate
// - offset bits 6:0 writable, 15:7 read as sign of bit 6
// - offset confined to +123 mV down to -125 mV
// - target plus offset above dac maximum clamps at the lower of ceiling and dac maximum, warns
// - out-of-range writes to offset, ceiling, margins flag invalid data, alert
// - ceiling holds 12 bits in 11:0; bits 15:12 read zero
// - while converting, target above ceiling slews to ceiling and sets status
// - ceiling written below present target gives the same clamp response
// - a ceiling below the floor takes precedence
// - margin high raises output by margin-up factor plus offset, slewed
// - margin-up holds 11 bits in 10:0; 15:11 read zero
// - restore loads margin-up with 528 or 536 from one default bit
// - margin-up codes are classed into percentage bands for storage
// - margin low lowers output by margin-down factor plus offset, slewed
// - exponent fixed at -9, about 1.953 mV per code
// - after soft-start a new target slews at once without waiting
module vtr_core (
    input wire logic sys_clk_i, // 100 MHz clock
    input wire logic rstn_i, // async reset, active low
    input wire logic ce_i, // clock enable, freezes all state when low
    input wire logic cmd_wr_i, // word write strobe from bus engine
    input wire logic cmd_rd_i, // word read strobe from bus engine
    input wire logic [7:0] cmd_code_i, // command code
    input wire logic [15:0] cmd_wdata_i, // write data word
    output logic [15:0] cmd_rdata_o, // read data word, registered
    output logic cmd_rvalid_o, // read data valid pulse
    input wire logic [7:0] operation_i, // operation command byte
    input wire logic [15:0] boot_voltage_offset_i, // stored boot value
    input wire logic [3:0] loop_scale_mant_i, // loop scale mantissa 1/2/4/8
    input wire logic [15:0] floor_i, // present lower limit
    input wire logic [7:0] transition_rate_i, // slew rate mantissa, 0.125 mV/us
    input wire logic converting_i, // conversion enabled, soft-start done
    input wire logic rail_disabled_i, // rail off by on/off or fault
    input wire logic address_or_reset_pin_i, // shared pin, async, low asserts
    input wire logic output_reset_pin_enable_i, // pin acts as output reset
    input wire logic nvm_restore_i, // nonvolatile restore pulse
    input wire logic margin_up_default_bit_i, // stored margin-up default
    input wire logic margin_down_default_bit_i, // stored margin-down default
    output logic [15:0] commanded_o, // clamped commanded code, before slew
    output logic [15:0] dac_code_o, // slewed code to the dac
    output logic limit_warn_o, // output warning pulse
    output logic status_word_vout_o, // output-group pulse
    output logic status_byte_other_o, // none-of-the-above pulse
    output logic invalid_data_o, // invalid data pulse
    output logic alert_o, // host notification pulse
    output logic [2:0] margin_up_band_o, // storage band of margin-up
    output logic margin_up_store_bit_o // default bit to store
);

    ////////////////////////////////////////////////////////////////////////
    // command registers
    logic [12:0] target_r;
    logic [6:0] offset_r;
    logic [11:0] ceiling_r;
    logic [10:0] mup_r;
    logic [9:0] mdn_r;
    logic boot_done_r;
    logic check_r;

    // pin synchroniser, three stages
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic pin_lvl_r;
    logic pin_fall;

    // decoded writes
    logic wr_target;
    logic wr_offset;
    logic wr_ceiling;
    logic wr_mup;
    logic wr_mdn;
    logic bad_offset;
    logic bad_ceiling;
    logic bad_mup;
    logic bad_mdn;
    logic reload_boot;
    logic [15:0] boot_code;

    // arithmetic
    logic signed [19:0] base_sum;
    logic signed [11:0] mup_delta;
    logic signed [11:0] mdn_delta;
    logic signed [25:0] mup_prod;
    logic signed [25:0] mdn_prod;
    logic signed [19:0] full_sum;
    logic signed [19:0] ceil_s;
    logic signed [19:0] floor_s;
    logic signed [19:0] dac_s;
    logic [15:0] commanded_nxt;
    logic clamp_hi;
    logic clamp_lo;
    logic full_over;
    logic dac_over;
    logic warn_nxt;

    ////////////////////////////////////////////////////////////////////////
    // address decode of write strobes
    always_comb begin
        wr_target = 1'b0;
        wr_offset = 1'b0;
        wr_ceiling = 1'b0;
        wr_mup = 1'b0;
        wr_mdn = 1'b0;
        if (cmd_wr_i && cmd_code_i == vtr_pkg::OFS_TARGET) begin
            wr_target = 1'b1;
        end else if (cmd_wr_i && cmd_code_i == vtr_pkg::OFS_OFFSET) begin
            wr_offset = 1'b1;
        end else if (cmd_wr_i && cmd_code_i == vtr_pkg::OFS_CEILING) begin
            wr_ceiling = 1'b1;
        end else if (cmd_wr_i && cmd_code_i == vtr_pkg::OFS_MARGIN_UP) begin
            wr_mup = 1'b1;
        end else if (cmd_wr_i && cmd_code_i == vtr_pkg::OFS_MARGIN_DOWN) begin
            wr_mdn = 1'b1;
        end
    end

    // validity: read-only upper bits must match what they would read
    // sign extension check
    assign bad_offset = (cmd_wdata_i[15:vtr_pkg::OFFSET_SIGN_BIT] != {10{cmd_wdata_i[6]}});
    assign bad_ceiling = (cmd_wdata_i[15:vtr_pkg::CEILING_W] != 4'h0);
    assign bad_mup = (cmd_wdata_i[15:vtr_pkg::MUP_W] != 5'h00);
    assign bad_mdn = (cmd_wdata_i[15:vtr_pkg::MDN_W] != 6'h00);

    ////////////////////////////////////////////////////////////////////////
    // address/reset pin: a change counts once stages two and three agree
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_s3_r <= 1'b1;
            pin_lvl_r <= 1'b1;
        end else if (ce_i) begin
            pin_s1_r <= address_or_reset_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) begin
                pin_lvl_r <= pin_s3_r;
            end
        end
    end

    assign pin_fall = pin_lvl_r && (pin_s2_r == pin_s3_r) && !pin_s3_r;

    // boot value is stored offset over loop scale mantissa
    always_comb begin
        case (loop_scale_mant_i)
            4'h2: boot_code = {1'b0, boot_voltage_offset_i[15:1]};
            4'h4: boot_code = {2'b00, boot_voltage_offset_i[15:2]};
            4'h8: boot_code = {3'b000, boot_voltage_offset_i[15:3]};
            default: boot_code = boot_voltage_offset_i;
        endcase
    end

    // disable, fault or pin reset all reload the boot value
    assign reload_boot = !boot_done_r || rail_disabled_i
        || (output_reset_pin_enable_i && pin_fall);

    ////////////////////////////////////////////////////////////////////////
    // commanded arithmetic at exponent -9
    always_comb begin
        base_sum = $signed({7'h00, target_r}) + $signed({{13{offset_r[6]}}, offset_r});
        mup_delta = $signed({1'b0, mup_r}) - $signed(vtr_pkg::FACTOR_UNITY);
        mdn_delta = $signed(vtr_pkg::FACTOR_UNITY) - $signed({2'b00, mdn_r});
        mup_prod = $signed({1'b0, target_r}) * mup_delta;
        mdn_prod = $signed({1'b0, target_r}) * mdn_delta;
        full_sum = base_sum;
        // margin high raises by margin-up factor
        if (operation_i[vtr_pkg::OP_MARGIN_HIGH_BIT]) begin
            full_sum = full_sum + 20'(mup_prod >>> vtr_pkg::FACTOR_SHIFT);
        end
        // margin low lowers by margin-down factor
        if (operation_i[vtr_pkg::OP_MARGIN_LOW_BIT]) begin
            full_sum = full_sum - 20'(mdn_prod >>> vtr_pkg::FACTOR_SHIFT);
        end
        ceil_s = $signed({8'h00, ceiling_r});
        floor_s = $signed({4'h0, floor_i});
        dac_s = $signed({4'h0, vtr_pkg::DAC_MAX_CODE});
    end

    // final clamp: lower of ceiling and dac range, then zero
    always_comb begin
        full_over = full_sum > ceil_s;
        dac_over = full_sum > dac_s;
        // above a ceiling no higher than the dac maximum the output goes to the ceiling
        if (full_over && ceil_s <= dac_s) begin
            commanded_nxt = {4'h0, ceiling_r};
        // above dac range the output sits at the dac maximum
        end else if (dac_over) begin
            commanded_nxt = vtr_pkg::DAC_MAX_CODE;
        end else if (full_sum < 20'sd0) begin
            commanded_nxt = 16'h0000;
        end else begin
            commanded_nxt = 16'(full_sum);
        end
    end

    // write-time limit test on target plus offset
    // ceiling tested first so it wins over the floor
    assign clamp_hi = base_sum > ceil_s || floor_s > ceil_s;
    assign clamp_lo = !clamp_hi && (base_sum < floor_s);
    assign warn_nxt = check_r && (clamp_hi || clamp_lo || dac_over
        || (converting_i && full_over));

    ////////////////////////////////////////////////////////////////////////
    // target register: boot reload beats writes
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            target_r <= vtr_pkg::RST_WORD[12:0];
            boot_done_r <= 1'b0;
        end else if (ce_i) begin
            boot_done_r <= 1'b1;
            if (reload_boot) begin
                target_r <= boot_code[12:0];
            // upper three bits dropped on write
            end else if (wr_target) begin
                target_r <= cmd_wdata_i[12:0];
            // clamp also follows a ceiling or offset write
            end else if (check_r && clamp_hi) begin
                target_r <= ceiling_r[11:0] + 13'h0000;
            end else if (check_r && clamp_lo) begin
                target_r <= floor_i[12:0];
            end
        end
    end

    // limit test deferred one cycle after any affecting write
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            check_r <= 1'b0;
        end else if (ce_i) begin
            check_r <= wr_target || wr_offset || (wr_ceiling && !bad_ceiling)
                || (wr_mup && !bad_mup) || (wr_mdn && !bad_mdn);
        end
    end

    // offset and ceiling; invalid writes leave the register untouched
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            offset_r <= vtr_pkg::RST_WORD[6:0];
            ceiling_r <= vtr_pkg::CEILING_DEFAULT;
        end else if (ce_i) begin
            // seven bits bound the offset to +123/-125 mV
            if (wr_offset && !bad_offset) begin
                offset_r <= cmd_wdata_i[6:0];
            end
            if (wr_ceiling && !bad_ceiling) begin
                ceiling_r <= cmd_wdata_i[11:0];
            end
        end
    end

    // margin factors, restored from one stored bit each
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mup_r <= vtr_pkg::MUP_DEFAULT_0;
            mdn_r <= vtr_pkg::MDN_DEFAULT_0;
        end else if (ce_i) begin
            if (nvm_restore_i) begin
                mup_r <= margin_up_default_bit_i ? vtr_pkg::MUP_DEFAULT_1
                    : vtr_pkg::MUP_DEFAULT_0;
                mdn_r <= margin_down_default_bit_i ? vtr_pkg::MDN_DEFAULT_1
                    : vtr_pkg::MDN_DEFAULT_0;
            end else begin
                if (wr_mup && !bad_mup) begin
                    mup_r <= cmd_wdata_i[10:0];
                end
                if (wr_mdn && !bad_mdn) begin
                    mdn_r <= cmd_wdata_i[9:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and notification pulses, one cycle each
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            limit_warn_o <= 1'b0;
            status_word_vout_o <= 1'b0;
            status_byte_other_o <= 1'b0;
            invalid_data_o <= 1'b0;
            alert_o <= 1'b0;
        end else if (ce_i) begin
            // warning feeds output and summary status bits
            limit_warn_o <= warn_nxt;
            status_word_vout_o <= warn_nxt;
            status_byte_other_o <= warn_nxt;
            invalid_data_o <= (wr_offset && bad_offset) || (wr_ceiling && bad_ceiling)
                || (wr_mup && bad_mup) || (wr_mdn && bad_mdn);
            alert_o <= warn_nxt || (wr_offset && bad_offset) || (wr_ceiling && bad_ceiling)
                || (wr_mup && bad_mup) || (wr_mdn && bad_mdn);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, answer one cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_rdata_o <= vtr_pkg::RST_WORD;
            cmd_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            cmd_rvalid_o <= cmd_rd_i;
            if (cmd_rd_i && cmd_code_i == vtr_pkg::OFS_TARGET) begin
                cmd_rdata_o <= {3'b000, target_r};
            end else if (cmd_rd_i && cmd_code_i == vtr_pkg::OFS_OFFSET) begin
                cmd_rdata_o <= {{9{offset_r[6]}}, offset_r};
            end else if (cmd_rd_i && cmd_code_i == vtr_pkg::OFS_CEILING) begin
                cmd_rdata_o <= {4'h0, ceiling_r};
            end else if (cmd_rd_i && cmd_code_i == vtr_pkg::OFS_MARGIN_UP) begin
                cmd_rdata_o <= {5'h00, mup_r};
            end else if (cmd_rd_i && cmd_code_i == vtr_pkg::OFS_MARGIN_DOWN) begin
                cmd_rdata_o <= {6'h00, mdn_r};
            end else if (cmd_rd_i) begin
                // unmapped codes read zero
                cmd_rdata_o <= vtr_pkg::RST_WORD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage band of margin-up, steps of eight codes
    logic [10:0] mup_rel;
    assign mup_rel = mup_r - vtr_pkg::MUP_BAND_LOW;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            margin_up_band_o <= 3'h0;
            margin_up_store_bit_o <= 1'b0;
        end else if (ce_i) begin
            if (mup_r < vtr_pkg::MUP_BAND_LOW) begin
                margin_up_band_o <= 3'h0;
            end else if (mup_r >= vtr_pkg::MUP_BAND_TOP) begin
                margin_up_band_o <= 3'h7;
            end else begin
                margin_up_band_o <= 3'(mup_rel >> vtr_pkg::MUP_BAND_STEP_LOG2) + 3'h1;
            end
            margin_up_store_bit_o <= (mup_r >= vtr_pkg::MUP_BAND_LOW)
                && ((3'(mup_rel >> vtr_pkg::MUP_BAND_STEP_LOG2) + 3'h1)
                >= vtr_pkg::MUP_BAND_BIT1_MIN) && (mup_r < vtr_pkg::MUP_BAND_TOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slew engine: rate credit added each microsecond, one code per cycle
    logic [7:0] tick_cnt_r;
    logic [11:0] credit_r;
    logic [7:0] rate_eff;
    logic tick;
    assign tick = (tick_cnt_r == 8'(vtr_pkg::SLEW_TICK_CYC - 1));
    // slowest supported setting used for tiny mantissas
    assign rate_eff = (transition_rate_i < vtr_pkg::RATE_FLOOR)
        ? vtr_pkg::RATE_FLOOR : transition_rate_i;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt_r <= 8'h00;
        end else if (ce_i) begin
            tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            commanded_o <= vtr_pkg::RST_WORD;
        end else if (ce_i) begin
            commanded_o <= commanded_nxt;
        end
    end

    // always steer toward the newest command, no waiting
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dac_code_o <= vtr_pkg::RST_WORD;
            credit_r <= 12'h000;
        end else if (ce_i) begin
            if (!converting_i) begin
                // soft-start and soft-stop ramps belong to another block
                dac_code_o <= commanded_o;
                credit_r <= 12'h000;
            end else if (dac_code_o == commanded_o) begin
                credit_r <= 12'h000;
            // offset, margin and target moves all slew here
            end else if (credit_r >= vtr_pkg::CODE_UNIT) begin
                credit_r <= credit_r - vtr_pkg::CODE_UNIT;
                dac_code_o <= (dac_code_o < commanded_o) ? dac_code_o + 16'h0001
                    : dac_code_o - 16'h0001;
            end else if (tick) begin
                credit_r <= credit_r + 12'(rate_eff * vtr_pkg::RATE_UNIT);
            end
        end
    end

endmodule
